// ===== src/asrd_defs.svh
// register offsets, reset values and decode constants of the amplifier setting bank
`ifndef ASRD_DEFS_SVH
`define ASRD_DEFS_SVH

`define ASRD_OFS_THRESH 8'h01
`define ASRD_OFS_PREEMPH 8'h02
`define ASRD_OFS_SWING 8'h03
`define ASRD_OFS_RATE_FIRST 8'h04
`define ASRD_OFS_RATE_SECOND 8'h05
`define ASRD_OFS_READBACK 8'h0e

`define ASRD_RST_THRESH 8'h80
`define ASRD_RST_PREEMPH 4'h0
`define ASRD_RST_SWING 2'h0
`define ASRD_RST_RATE 8'h00

`define ASRD_RATE_EN_BIT 7
`define ASRD_THRESH_ZERO 8'h80

// serial device address, value is arbitrary
`define ASRD_DEV_ADDR 7'h5a

// codes reported while a default bandwidth is in effect, values are arbitrary
`define ASRD_DEF_CODE_FIRST 4'h2
`define ASRD_DEF_CODE_SECOND 4'h7
`define ASRD_DEF_CODE_OTHER 4'h0
`define ASRD_DEF_MHZ_FIRST 14'h0960
`define ASRD_DEF_MHZ_SECOND 14'h1db0
`define ASRD_DEF_MHZ_NONE 14'h0000

`define ASRD_SWING_LOW_MV 10'h15e
`define ASRD_SWING_MID_MV 10'h28a
`define ASRD_SWING_HIGH_MV 10'h352

`endif

// ===== src/asrd_pkg.sv
// types shared by the amplifier setting bank
package asrd_pkg;

	typedef enum logic [1:0] {
		DIR_ZERO = 2'b00,
		DIR_POS = 2'b01,
		DIR_NEG = 2'b10
	} asrd_shift_dir_t;

	typedef enum logic [3:0] {
		BUS_IDLE = 4'b0000,
		BUS_ADDR = 4'b0001,
		BUS_ACK_ADDR = 4'b0010,
		BUS_WPTR = 4'b0011,
		BUS_ACK_PTR = 4'b0100,
		BUS_WDATA = 4'b0101,
		BUS_ACK_DATA = 4'b0110,
		BUS_RDATA = 4'b0111,
		BUS_RACK = 4'b1000
	} asrd_bus_state_t;

endpackage

// ===== src/asrd_decode.sv
// combinational decode of the setting fields and rate resolution
`timescale 1ns/1ps
`include "asrd_defs.svh"
module asrd_decode import asrd_pkg::*; (
	// stored fields
	input wire logic [7:0] thresh_code_i,
	input wire logic [3:0] preemph_code_i,
	input wire logic [1:0] swing_code_i,
	input wire logic [7:0] rate_first_i,
	input wire logic [7:0] rate_second_i,
	// synchronised rate pins
	input wire logic rate_pin_high_i,
	input wire logic rate_pin_low_i,
	// decoded settings
	output asrd_shift_dir_t thresh_dir_o,
	output logic [6:0] thresh_mag_o,
	output logic [3:0] preemph_db_o,
	output logic [9:0] swing_mv_o,
	output logic [3:0] bw_code_o,
	output logic bw_default_o,
	output logic [13:0] bw_mhz_o
);
	logic [7:0] pos_mag;

	always_comb begin
		pos_mag = `ASRD_THRESH_ZERO - thresh_code_i;
		if (thresh_code_i != 8'h00 && !thresh_code_i[7]) begin
			thresh_dir_o = DIR_POS;
			thresh_mag_o = pos_mag[6:0];
		end else if (thresh_code_i[7] && thresh_code_i[6:0] != 7'h00) begin
			thresh_dir_o = DIR_NEG;
			thresh_mag_o = thresh_code_i[6:0];
		end else begin
			thresh_dir_o = DIR_ZERO;
			thresh_mag_o = 7'h00;
		end
		case (preemph_code_i)
			4'h1: preemph_db_o = 4'h1;
			4'h3: preemph_db_o = 4'h2;
			4'h4: preemph_db_o = 4'h3;
			4'h5: preemph_db_o = 4'h4;
			4'h7: preemph_db_o = 4'h5;
			4'hc: preemph_db_o = 4'h6;
			4'hd: preemph_db_o = 4'h7;
			4'hf: preemph_db_o = 4'h8;
			default: preemph_db_o = 4'h0;
		endcase
		case (swing_code_i)
			2'b00: swing_mv_o = `ASRD_SWING_LOW_MV;
			2'b11: swing_mv_o = `ASRD_SWING_HIGH_MV;
			default: swing_mv_o = `ASRD_SWING_MID_MV;
		endcase
		if (!rate_pin_high_i && !rate_pin_low_i) begin
			bw_default_o = !rate_first_i[`ASRD_RATE_EN_BIT];
			bw_code_o = bw_default_o ? `ASRD_DEF_CODE_FIRST : rate_first_i[3:0];
			bw_mhz_o = bw_default_o ? `ASRD_DEF_MHZ_FIRST : `ASRD_DEF_MHZ_NONE;
		end else if (!rate_pin_high_i && rate_pin_low_i) begin
			bw_default_o = !rate_second_i[`ASRD_RATE_EN_BIT];
			bw_code_o = bw_default_o ? `ASRD_DEF_CODE_SECOND : rate_second_i[3:0];
			bw_mhz_o = bw_default_o ? `ASRD_DEF_MHZ_SECOND : `ASRD_DEF_MHZ_NONE;
		end else begin
			bw_default_o = 1'b1;
			bw_code_o = `ASRD_DEF_CODE_OTHER;
			bw_mhz_o = `ASRD_DEF_MHZ_NONE;
		end
	end
endmodule

// ===== src/asrd_regbank.sv
// amplifier setting bank: two-wire slave, setting registers, registered decode
`timescale 1ns/1ps
`include "asrd_defs.svh"
module asrd_regbank import asrd_pkg::*; (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// two-wire serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// rate select pins
	input wire logic rate_pin_high_i,
	input wire logic rate_pin_low_i,
	// decoded settings
	output asrd_shift_dir_t thresh_dir_o,
	output logic [6:0] thresh_mag_o,
	output logic [3:0] preemph_db_o,
	output logic [9:0] swing_mv_o,
	output logic [3:0] filter_bw_code_o,
	output logic filter_bw_default_o,
	output logic [13:0] filter_bw_default_mhz_o
);
	logic [1:0] scl_sync_reg, sda_sync_reg, pin_sync0_reg, pin_sync1_reg;
	logic scl_d_reg, sda_d_reg;
	logic scl_rise, scl_fall, bus_start, bus_stop, wr_en;
	asrd_bus_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next, tx_reg, tx_next, ptr_reg, ptr_next, rd_data;
	logic rw_reg, rw_next, nack_reg, nack_next, oe_reg, oe_next;
	logic [7:0] thresh_reg, thresh_next, rate_first_reg, rate_first_next;
	logic [7:0] rate_second_reg, rate_second_next;
	logic [3:0] preemph_reg, preemph_next;
	logic [1:0] swing_reg, swing_next;
	asrd_shift_dir_t dec_dir;
	logic [6:0] dec_mag;
	logic [3:0] dec_db, dec_code;
	logic [9:0] dec_mv;
	logic dec_default;
	logic [13:0] dec_mhz;
	// readback of a register by offset, unmapped and reserved bits read zero
	function automatic logic [7:0] read_reg(input logic [7:0] ofs);
		case (ofs)
			`ASRD_OFS_THRESH: read_reg = thresh_reg;
			`ASRD_OFS_PREEMPH: read_reg = {4'h0, preemph_reg};
			`ASRD_OFS_SWING: read_reg = {6'h00, swing_reg};
			`ASRD_OFS_RATE_FIRST: read_reg = rate_first_reg;
			`ASRD_OFS_RATE_SECOND: read_reg = rate_second_reg;
			`ASRD_OFS_READBACK: read_reg = {4'h0, filter_bw_code_o};
			default: read_reg = 8'h00;
		endcase
	endfunction
	// edges seen only on the second synchroniser stage
	assign scl_rise = scl_sync_reg[1] && !scl_d_reg;
	assign scl_fall = !scl_sync_reg[1] && scl_d_reg;
	assign bus_start = scl_sync_reg[1] && scl_d_reg && sda_d_reg && !sda_sync_reg[1];
	assign bus_stop = scl_sync_reg[1] && scl_d_reg && !sda_d_reg && sda_sync_reg[1];
	// process form so the mux also follows the stored fields, not just the pointer
	always_comb rd_data = read_reg(ptr_reg);
	assign wr_en = !bus_start && !bus_stop && scl_fall && state_reg == BUS_WDATA
		&& cnt_reg == 4'h8;
	assign sda_o = 1'b0;
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		rw_next = rw_reg;
		nack_next = nack_reg;
		oe_next = oe_reg;
		if (bus_stop) begin
			state_next = BUS_IDLE;
			oe_next = 1'b0;
		end else if (bus_start) begin
			state_next = BUS_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				BUS_ADDR, BUS_WPTR, BUS_WDATA: begin
					shift_next = {shift_reg[6:0], sda_sync_reg[1]};
					cnt_next = cnt_reg + 4'h1;
				end
				BUS_RDATA: cnt_next = cnt_reg + 4'h1;
				BUS_RACK: nack_next = sda_sync_reg[1];
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				BUS_ADDR: if (cnt_reg == 4'h8) begin
					cnt_next = 4'h0;
					rw_next = shift_reg[0];
					oe_next = shift_reg[7:1] == `ASRD_DEV_ADDR;
					state_next = oe_next ? BUS_ACK_ADDR : BUS_IDLE;
				end
				BUS_ACK_ADDR: begin
					if (rw_reg) begin
						state_next = BUS_RDATA;
						tx_next = rd_data;
						oe_next = !rd_data[7];
						ptr_next = ptr_reg + 8'h01;
					end else begin
						state_next = BUS_WPTR;
						oe_next = 1'b0;
					end
				end
				BUS_WPTR: if (cnt_reg == 4'h8) begin
					cnt_next = 4'h0;
					ptr_next = shift_reg;
					oe_next = 1'b1;
					state_next = BUS_ACK_PTR;
				end
				BUS_WDATA: if (cnt_reg == 4'h8) begin
					cnt_next = 4'h0;
					ptr_next = ptr_reg + 8'h01;
					oe_next = 1'b1;
					state_next = BUS_ACK_DATA;
				end
				BUS_ACK_PTR, BUS_ACK_DATA: begin
					oe_next = 1'b0;
					state_next = BUS_WDATA;
				end
				BUS_RDATA: begin
					if (cnt_reg == 4'h8) begin
						cnt_next = 4'h0;
						oe_next = 1'b0;
						state_next = BUS_RACK;
					end else begin
						tx_next = {tx_reg[6:0], 1'b0};
						oe_next = !tx_reg[6];
					end
				end
				BUS_RACK: begin
					if (nack_reg) begin
						state_next = BUS_IDLE;
					end else begin
						state_next = BUS_RDATA;
						tx_next = rd_data;
						oe_next = !rd_data[7];
						ptr_next = ptr_reg + 8'h01;
					end
				end
				default: ;
			endcase
		end
	end
	always_comb begin
		thresh_next = thresh_reg;
		preemph_next = preemph_reg;
		swing_next = swing_reg;
		rate_first_next = rate_first_reg;
		rate_second_next = rate_second_reg;
		// fields change only on a host write
		if (wr_en) begin
			case (ptr_reg)
				`ASRD_OFS_THRESH: thresh_next = shift_reg;
				`ASRD_OFS_PREEMPH: preemph_next = shift_reg[3:0];
				`ASRD_OFS_SWING: swing_next = shift_reg[1:0];
				// keep enable flag and code only
				`ASRD_OFS_RATE_FIRST: rate_first_next = {shift_reg[7], 3'h0, shift_reg[3:0]};
				`ASRD_OFS_RATE_SECOND: rate_second_next = {shift_reg[7], 3'h0, shift_reg[3:0]};
				default: ;
			endcase
		end
	end
	asrd_decode u_decode (
		.thresh_code_i(thresh_reg),
		.preemph_code_i(preemph_reg),
		.swing_code_i(swing_reg),
		.rate_first_i(rate_first_reg),
		.rate_second_i(rate_second_reg),
		.rate_pin_high_i(pin_sync1_reg[1]),
		.rate_pin_low_i(pin_sync0_reg[1]),
		.thresh_dir_o(dec_dir),
		.thresh_mag_o(dec_mag),
		.preemph_db_o(dec_db),
		.swing_mv_o(dec_mv),
		.bw_code_o(dec_code),
		.bw_default_o(dec_default),
		.bw_mhz_o(dec_mhz)
	);
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			pin_sync0_reg <= 2'b00;
			pin_sync1_reg <= 2'b00;
			state_reg <= BUS_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			nack_reg <= 1'b0;
			oe_reg <= 1'b0;
			thresh_reg <= `ASRD_RST_THRESH;
			preemph_reg <= `ASRD_RST_PREEMPH;
			swing_reg <= `ASRD_RST_SWING;
			rate_first_reg <= `ASRD_RST_RATE;
			rate_second_reg <= `ASRD_RST_RATE;
			thresh_dir_o <= DIR_ZERO;
			thresh_mag_o <= 7'h00;
			preemph_db_o <= 4'h0;
			swing_mv_o <= `ASRD_SWING_LOW_MV;
			filter_bw_code_o <= `ASRD_DEF_CODE_FIRST;
			filter_bw_default_o <= 1'b1;
			filter_bw_default_mhz_o <= `ASRD_DEF_MHZ_FIRST;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
			pin_sync0_reg <= {pin_sync0_reg[0], rate_pin_low_i};
			pin_sync1_reg <= {pin_sync1_reg[0], rate_pin_high_i};
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			rw_reg <= rw_next;
			nack_reg <= nack_next;
			oe_reg <= oe_next;
			thresh_reg <= thresh_next;
			preemph_reg <= preemph_next;
			swing_reg <= swing_next;
			rate_first_reg <= rate_first_next;
			rate_second_reg <= rate_second_next;
			thresh_dir_o <= dec_dir;
			thresh_mag_o <= dec_mag;
			preemph_db_o <= dec_db;
			swing_mv_o <= dec_mv;
			filter_bw_code_o <= dec_code;
			filter_bw_default_o <= dec_default;
			filter_bw_default_mhz_o <= dec_mhz;
		end
	end
	assign sda_oe_o = oe_reg;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_thresh_pos: assert property ((thresh_reg != 8'h00 && !thresh_reg[7]) |=>
		(thresh_dir_o == DIR_POS && {1'b0, thresh_mag_o} == 8'h80 - $past(thresh_reg)))
		else $error("positive threshold shift wrong");
	chk_thresh_neg: assert property ((thresh_reg >= 8'h80) |=>
		(thresh_mag_o == $past(thresh_reg[6:0])
		&& thresh_dir_o == (thresh_mag_o == 7'h00 ? DIR_ZERO : DIR_NEG)))
		else $error("zero or negative threshold shift wrong");
	chk_preemph_map: assert property ((preemph_reg == 4'hc) |=> (preemph_db_o == 4'h6))
		else $error("preemphasis decode wrong");
	chk_swing_mid: assert property ((swing_reg inside {2'b01, 2'b10}) |=>
		(swing_mv_o == `ASRD_SWING_MID_MV)) else $error("swing decode wrong");
	chk_rate_unused: assert property ((rate_first_reg[6:4] == 3'h0)
		&& (rate_second_reg[6:4] == 3'h0)) else $error("unused rate bits stored");
	chk_first_code: assert property ((!pin_sync1_reg[1] && !pin_sync0_reg[1]
		&& rate_first_reg[7]) |=> (!filter_bw_default_o
		&& filter_bw_code_o == $past(rate_first_reg[3:0])))
		else $error("register A code not applied");
	chk_first_default: assert property ((!pin_sync1_reg[1] && !pin_sync0_reg[1]
		&& !rate_first_reg[7]) |=> (filter_bw_default_o
		&& filter_bw_default_mhz_o == `ASRD_DEF_MHZ_FIRST))
		else $error("register A default not applied");
	chk_second_code: assert property ((!pin_sync1_reg[1] && pin_sync0_reg[1]
		&& rate_second_reg[7]) |=> (!filter_bw_default_o
		&& filter_bw_code_o == $past(rate_second_reg[3:0])))
		else $error("register B code not applied");
	chk_second_default: assert property ((!pin_sync1_reg[1] && pin_sync0_reg[1]
		&& !rate_second_reg[7]) |=> (filter_bw_default_o
		&& filter_bw_default_mhz_o == `ASRD_DEF_MHZ_SECOND))
		else $error("register B default not applied");
	sequence s_read_load;
		scl_fall && !bus_stop && !bus_start && state_reg == BUS_ACK_ADDR && rw_reg
			&& ptr_reg == `ASRD_OFS_READBACK;
	endsequence
	chk_readback_load: assert property (s_read_load |=>
		(state_reg == BUS_RDATA && tx_reg == {4'h0, $past(filter_bw_code_o)}))
		else $error("readback byte wrong");
	chk_hold_value: assert property (!wr_en |=> ($stable(thresh_reg)
		&& $stable(rate_first_reg) && $stable(rate_second_reg)))
		else $error("setting changed without write");
endmodule

// ===== test/asrd_host_model.sv
// two-wire bus host that drives the setting bank from the bench
`timescale 1ns/1ps
`include "asrd_defs.svh"
module asrd_host_model (
	// clock
	input wire logic ref_clk_i,
	// bus wire level and host drive
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// scl is low on entry and exit, data moves only while scl is low
	task automatic put_bit(input logic b);
		sda_oe_o <= ~b;
		wt(5);
		scl_o <= 1'b1;
		wt(10);
		scl_o <= 1'b0;
		wt(5);
	endtask
	task automatic get_bit(output logic b);
		sda_oe_o <= 1'b0;
		wt(5);
		scl_o <= 1'b1;
		wt(5);
		b = sda_i;
		wt(5);
		scl_o <= 1'b0;
		wt(5);
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask
	task automatic start_cond();
		sda_oe_o <= 1'b1;
		wt(10);
		scl_o <= 1'b0;
		wt(5);
	endtask
	task automatic stop_cond();
		sda_oe_o <= 1'b1;
		wt(5);
		scl_o <= 1'b1;
		wt(10);
		sda_oe_o <= 1'b0;
		wt(20);
	endtask
	task automatic write_dev(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
		output logic ack);
		logic a0, a1, a2;
		start_cond();
		send_byte({dev, 1'b0}, a0);
		send_byte(p, a1);
		send_byte(d, a2);
		stop_cond();
		ack = a0 & a1 & a2;
	endtask
	// single byte read, ended by a not-acknowledge
	task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
		logic a;
		start_cond();
		send_byte({`ASRD_DEV_ADDR, 1'b0}, a);
		send_byte(p, a);
		sda_oe_o <= 1'b0;
		wt(5);
		scl_o <= 1'b1;
		wt(10);
		start_cond();
		send_byte({`ASRD_DEV_ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(1'b1);
		stop_cond();
	endtask
endmodule

// ===== test/tb_asrd_regbank.sv
// self-checking bench of the amplifier setting bank
`timescale 1ns/1ps
`include "asrd_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_asrd_regbank import asrd_pkg::*; ();
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic pin_hi = 1'b0;
	logic pin_lo = 1'b0;
	logic scl;
	logic host_oe;
	logic dev_oe;
	logic sda_val;
	wire sda_w;
	asrd_shift_dir_t dir;
	logic [6:0] mag;
	logic [3:0] pe_db;
	logic [9:0] sw;
	logic [3:0] bw;
	logic bw_def;
	logic [13:0] mhz;
	logic [7:0] rd;
	logic [7:0] c;
	logic [7:0] seed = 8'h38;
	logic ack;
	logic [7:0] th_codes [5] = '{8'h01, 8'h7f, 8'h80, 8'h81, 8'hff};
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	// pulled-up open-drain data wire
	assign sda_w = ~host_oe & (~dev_oe | sda_val);
	always #5 ref_clk_i = ~ref_clk_i;
	asrd_regbank uut (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_val), .sda_oe_o(dev_oe), .rate_pin_high_i(pin_hi), .rate_pin_low_i(pin_lo),
		.thresh_dir_o(dir), .thresh_mag_o(mag), .preemph_db_o(pe_db), .swing_mv_o(sw),
		.filter_bw_code_o(bw), .filter_bw_default_o(bw_def), .filter_bw_default_mhz_o(mhz)
	);
	asrd_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(host_oe));
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function automatic asrd_shift_dir_t exp_dir(input logic [7:0] v);
		if (v == 8'h00 || v == 8'h80) return DIR_ZERO;
		return (v < 8'h80) ? DIR_POS : DIR_NEG;
	endfunction
	// code 0 wraps to a magnitude of 0 as well
	function automatic logic [6:0] exp_mag(input logic [7:0] v);
		logic [7:0] m;
		m = v[7] ? v - 8'h80 : 8'h80 - v;
		return m[6:0];
	endfunction
	function automatic logic [3:0] exp_db(input logic [3:0] v);
		case (v)
			4'h1: return 4'h1;
			4'h3: return 4'h2;
			4'h4: return 4'h3;
			4'h5: return 4'h4;
			4'h7: return 4'h5;
			4'hc: return 4'h6;
			4'hd: return 4'h7;
			4'hf: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction
	function automatic logic [9:0] exp_mv(input logic [1:0] v);
		if (v == 2'h0) return `ASRD_SWING_LOW_MV;
		if (v == 2'h3) return `ASRD_SWING_HIGH_MV;
		return `ASRD_SWING_MID_MV;
	endfunction
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		host.write_dev(`ASRD_DEV_ADDR, p, d, ack);
		`CHK(ack, 1'b1)
	endtask
	task automatic chk_rd(input logic [7:0] p, input logic [7:0] e);
		host.read_reg(p, rd);
		`CHK(rd, e)
	endtask
	task automatic chk_rate(input logic [3:0] code, input logic d, input logic [13:0] m);
		`CHK(bw, code)
		`CHK(bw_def, d)
		`CHK(mhz, m)
		chk_rd(`ASRD_OFS_READBACK, {4'h0, code});
	endtask
	task automatic set_pins(input logic h, input logic l);
		pin_hi <= h;
		pin_lo <= l;
		repeat (6) @(posedge ref_clk_i);
	endtask
	task automatic print_verdict();
		$display("counts: %0d checked, %0d mismatches", checked, err_count);
		if (err_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		`CHK(dir, DIR_ZERO)
		`CHK(sw, `ASRD_SWING_LOW_MV)
		chk_rate(`ASRD_DEF_CODE_FIRST, 1'b1, `ASRD_DEF_MHZ_FIRST);
		$display("test reset done");
		// corner codes first, then random ones
		for (int i = 0; i < 13; i++) begin
			c = (i < 5) ? th_codes[i] : seed;
			seed = lfsr(seed);
			wr(`ASRD_OFS_THRESH, c);
			`CHK(dir, exp_dir(c))
			`CHK(mag, exp_mag(c))
		end
		chk_rd(`ASRD_OFS_THRESH, c);
		$display("test threshold done");
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			wr(`ASRD_OFS_PREEMPH, {seed[7:4], i[3:0]});
			`CHK(pe_db, exp_db(i[3:0]))
		end
		`CHK(mag, exp_mag(c))
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(`ASRD_OFS_SWING, {seed[7:2], i[1:0]});
			`CHK(sw, exp_mv(i[1:0]))
		end
		$display("test preemphasis and swing done");
		c = {4'hf, seed[3:0]};
		wr(`ASRD_OFS_RATE_FIRST, c);
		chk_rd(`ASRD_OFS_RATE_FIRST, {c[7], 3'h0, c[3:0]});
		chk_rate(c[3:0], 1'b0, `ASRD_DEF_MHZ_NONE);
		wr(`ASRD_OFS_READBACK, {4'h0, ~c[3:0]});
		chk_rate(c[3:0], 1'b0, `ASRD_DEF_MHZ_NONE);
		wr(`ASRD_OFS_RATE_FIRST, {4'h7, c[3:0]});
		chk_rate(`ASRD_DEF_CODE_FIRST, 1'b1, `ASRD_DEF_MHZ_FIRST);
		wr(`ASRD_OFS_RATE_SECOND, 8'h8a);
		set_pins(1'b0, 1'b1);
		chk_rate(4'ha, 1'b0, `ASRD_DEF_MHZ_NONE);
		wr(`ASRD_OFS_RATE_SECOND, 8'h7a);
		chk_rate(`ASRD_DEF_CODE_SECOND, 1'b1, `ASRD_DEF_MHZ_SECOND);
		set_pins(1'b1, 1'b0);
		chk_rate(`ASRD_DEF_CODE_OTHER, 1'b1, `ASRD_DEF_MHZ_NONE);
		set_pins(1'b1, 1'b1);
		chk_rate(`ASRD_DEF_CODE_OTHER, 1'b1, `ASRD_DEF_MHZ_NONE);
		set_pins(1'b0, 1'b0);
		chk_rate(`ASRD_DEF_CODE_FIRST, 1'b1, `ASRD_DEF_MHZ_FIRST);
		$display("test rate select done");
		chk_rd(8'h20, 8'h00);
		host.write_dev(~(`ASRD_DEV_ADDR), `ASRD_OFS_SWING, 8'h00, ack);
		`CHK(ack, 1'b0)
		`CHK(sw, `ASRD_SWING_HIGH_MV)
		$display("test refused access done");
		print_verdict();
	end
endmodule
